// [design/rsl_pkg.sv]
// shared constants for the remote shutdown relay logic
package rsl_pkg;
    localparam int RULES_DEF = 8;
    localparam int DATA_W = 32;
    localparam int ID_W = 8;
    localparam int CH_W = 4;
    localparam int PT_W = 16;
    localparam int LW = 16;
    // comparison operators
    localparam logic [1:0] OP_GT = 2'h0;
    localparam logic [1:0] OP_LT = 2'h1;
    localparam logic [1:0] OP_EQ = 2'h2;
    localparam logic [1:0] OP_OFF = 2'h3;
    // gateway address and event log map
    localparam logic [ID_W-1:0] GW_ADDR_DEF = 8'hf7;
    localparam logic [15:0] LOG_BASE = 16'h1b58;
    localparam int LOG_ENTRIES = 5;
    localparam int LOG_WORDS = 5;
    localparam logic [15:0] LOG_SPAN = 16'h0019;
    // pulse timebase
    localparam longint CLK_HZ = 200000000;
    localparam longint PULSE_UNIT_S = 1;
    localparam int SEC_CYCLES = int'(CLK_HZ * PULSE_UNIT_S);
endpackage

// [design/rsl_rule_eval.sv]
// one rule: energize / de-energize compare with hysteresis hold
`timescale 1ns/1ps
module rsl_rule_eval
    import rsl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic valid,
    input wire logic [DATA_W-1:0] value,
    input wire logic [1:0] en_op,
    input wire logic [DATA_W-1:0] en_thr,
    input wire logic [1:0] de_op,
    input wire logic [DATA_W-1:0] de_thr,
    output logic result
);
    function automatic logic cmp(input logic [1:0] op, input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
        unique case (op)
            OP_GT: cmp = a > b;
            OP_LT: cmp = a < b;
            OP_EQ: cmp = a == b;
            default: cmp = 1'b0;
        endcase
    endfunction

    wire logic en_hit = cmp(en_op, value, en_thr);  // see [RULE_11]
    wire logic de_hit = cmp(de_op, value, de_thr);  // see [RULE_11]

    // de-energize wins when both thresholds match; neither holds
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            result <= 1'b0;  // see [RULE_10]
        end else if (clear) begin
            result <= 1'b0;
        end else if (valid && de_hit) begin
            result <= 1'b0;  // see [RULE_11]
        end else if (valid && en_hit) begin
            result <= 1'b1;
        end  // see [RULE_14]
    end

    property p_hold;
        @(posedge sys_clk) disable iff (!rst_b)
        !clear && !(valid && (en_hit || de_hit)) |=> $stable(result);
    endproperty
    a_hold: assert property (p_hold) else $error("rule result changed without a match");  // see [RULE_14]

    property p_de;
        @(posedge sys_clk) disable iff (!rst_b)
        valid && de_hit |=> !result;
    endproperty
    a_de: assert property (p_de) else $error("de-energize match did not clear result");  // see [RULE_11]
endmodule

// [design/rsl_remote_shutdown_logic.sv]
// remote shutdown relay decision logic with event log
//
// Summary of operation
// [RULE_01] same destination: AND energize, any de-energize wins
// [RULE_02] five recent shutdowns readable at 7000-7024
// [RULE_03] readable log cleared by every reset
// [RULE_04] every shutdown also sent to internal log
// [RULE_05] failsafe: missing data de-energizes relay
// [RULE_06] no failsafe: missing nodes are ignored
// [RULE_07] latch: rules may only de-energize
// [RULE_08] latch: client coil write re-energizes relay
// [RULE_09] latch: storing settings forces relays off
// [RULE_10] de-energized is the safe default state
// [RULE_11] energize and de-energize thresholds give hysteresis
// [RULE_12] pulse mode pulses relay on run or shutdown
// [RULE_13] gateway address selects local digital outputs
// [RULE_14] no threshold met holds previous rule result
`timescale 1ns/1ps
module rsl_remote_shutdown_logic
    import rsl_pkg::*;
#(
    parameter int NUM_RULES = RULES_DEF,
    parameter int NUM_LOCAL = 2,
    parameter int TICKS_PER_SEC = SEC_CYCLES
)(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic failsafe_en,
    input wire logic hold_off_until_client_write,
    input wire logic settings_store,
    input wire logic [ID_W-1:0] gateway_addr,
    input wire logic [NUM_RULES-1:0] rule_en,
    input wire logic [NUM_RULES-1:0] src_valid,
    input wire logic [DATA_W-1:0] src_value [NUM_RULES],
    input wire logic [1:0] en_op [NUM_RULES],
    input wire logic [DATA_W-1:0] en_thr [NUM_RULES],
    input wire logic [1:0] de_op [NUM_RULES],
    input wire logic [DATA_W-1:0] de_thr [NUM_RULES],
    input wire logic [ID_W-1:0] dest_id [NUM_RULES],
    input wire logic [CH_W-1:0] dest_ch [NUM_RULES],
    input wire logic [NUM_RULES-1:0] pulse_mode,
    input wire logic [NUM_RULES-1:0] pulse_on_run,
    input wire logic [PT_W-1:0] pulse_time [NUM_RULES],
    input wire logic coil_wr,
    input wire logic [ID_W-1:0] coil_id,
    input wire logic [CH_W-1:0] coil_ch,
    input wire logic coil_val,
    input wire logic log_rd_en,
    input wire logic [15:0] log_rd_addr,
    output logic [NUM_RULES-1:0] dest_relay,
    output logic [NUM_LOCAL-1:0] local_dout,
    output logic log_rd_valid,
    output logic [LW-1:0] log_rd_data,
    output logic evt_strobe,
    output logic [7:0] evt_rule,
    output logic [ID_W-1:0] evt_dest_id,
    output logic [CH_W-1:0] evt_dest_ch
);
    localparam int RI_W = $clog2(NUM_RULES);
    localparam int TK_W = $clog2(TICKS_PER_SEC + 1);

    ////////////////////////////////////////////////////////////////////////
    // rule evaluation
    logic [NUM_RULES-1:0] res;
    logic [NUM_RULES-1:0] ok;
    logic [NUM_RULES-1:0] target;
    logic [NUM_RULES-1:0] leader;
    logic [NUM_RULES-1:0] coil_hit;
    logic [NUM_RULES-1:0] relay_on;
    logic [NUM_RULES-1:0] fire;
    logic [NUM_RULES-1:0] fire_go;
    logic [NUM_RULES-1:0] relay_nx;
    logic [NUM_RULES-1:0] pulse_act;
    logic [PT_W-1:0] pulse_cnt [NUM_RULES];
    logic [NUM_RULES-1:0] evt_pend;
    logic latch_store;

    assign latch_store = hold_off_until_client_write && settings_store;

    // latch: rules only switch off, a client write re-arms, a latched store forces all off
    assign relay_nx = latch_store ? '0 :  // see [RULE_09]
                      hold_off_until_client_write ? (target & (relay_on | coil_hit)) :  // see [RULE_07] see [RULE_08]
                      target;  // see [RULE_01]

    genvar g;
    generate
        for (g = 0; g < NUM_RULES; g++) begin : gen_rule
            rsl_rule_eval u_eval (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .clear(settings_store),
                .valid(src_valid[g]),
                .value(src_value[g]),
                .en_op(en_op[g]),
                .en_thr(en_thr[g]),
                .de_op(de_op[g]),
                .de_thr(de_thr[g]),
                .result(res[g])
            );
            // invalid data counts as de-energize only under failsafe
            assign ok[g] = src_valid[g] ? res[g] : !failsafe_en;  // see [RULE_05] see [RULE_06]
            assign coil_hit[g] = coil_wr && coil_val && coil_id == dest_id[g] && coil_ch == dest_ch[g];
            assign fire[g] = pulse_on_run[g] ? (relay_nx[g] && !relay_on[g]) : (!relay_nx[g] && relay_on[g]);
            assign fire_go[g] = fire[g] && pulse_time[g] != '0;
        end
    endgenerate

    // group AND over rules sharing destination id and channel
    always_comb begin
        for (int i = 0; i < NUM_RULES; i++) begin
            logic any_valid;
            logic all_ok;
            any_valid = 1'b0;
            all_ok = 1'b1;
            leader[i] = 1'b1;
            for (int j = 0; j < NUM_RULES; j++) begin
                if (rule_en[j] && dest_id[j] == dest_id[i] && dest_ch[j] == dest_ch[i]) begin
                    all_ok = all_ok && ok[j];  // see [RULE_01]
                    any_valid = any_valid || src_valid[j];
                    if (j < i) begin
                        leader[i] = 1'b0;
                    end
                end
            end
            // a group with no live node stays safe
            target[i] = rule_en[i] && all_ok && any_valid;  // see [RULE_10]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // relay state, latch and pulse
    logic [TK_W-1:0] tick_cnt;
    logic sec_tick;
    logic [31:0] sec_count;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt <= '0;
            sec_tick <= 1'b0;
            sec_count <= '0;
        end else begin
            sec_tick <= tick_cnt == TK_W'(TICKS_PER_SEC - 1);
            tick_cnt <= (tick_cnt == TK_W'(TICKS_PER_SEC - 1)) ? '0 : tick_cnt + 1'b1;
            if (sec_tick) begin
                sec_count <= sec_count + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            relay_on <= '0;  // see [RULE_10]
        end else begin
            relay_on <= relay_nx;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_act <= '0;
            for (int i = 0; i < NUM_RULES; i++) begin
                pulse_cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_RULES; i++) begin
                if (fire_go[i]) begin
                    pulse_act[i] <= 1'b1;  // see [RULE_12]
                    pulse_cnt[i] <= pulse_time[i];
                end else if (pulse_act[i] && sec_tick) begin
                    pulse_cnt[i] <= pulse_cnt[i] - 1'b1;
                    pulse_act[i] <= pulse_cnt[i] != PT_W'(1);
                end
            end
        end
    end

    logic [NUM_RULES-1:0] next_dest_relay;
    logic [NUM_LOCAL-1:0] next_local_dout;
    assign next_dest_relay = (pulse_mode & (pulse_act | fire_go)) | (~pulse_mode & relay_on);

    always_comb begin
        next_local_dout = '0;
        for (int c = 0; c < NUM_LOCAL; c++) begin
            for (int i = 0; i < NUM_RULES; i++) begin
                if (rule_en[i] && dest_id[i] == gateway_addr && dest_ch[i] == CH_W'(c)) begin
                    next_local_dout[c] = next_local_dout[c] | next_dest_relay[i];  // see [RULE_13]
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dest_relay <= '0;
            local_dout <= '0;
        end else begin
            dest_relay <= next_dest_relay;
            local_dout <= next_local_dout;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shutdown events and readable log
    logic [NUM_RULES-1:0] shut;
    logic [NUM_RULES-1:0] pick;
    logic [RI_W-1:0] pick_idx;
    logic [LW-1:0] log_mem [LOG_ENTRIES][LOG_WORDS];
    logic [2:0] wr_ptr;
    logic [LW-1:0] seq;
    wire logic [15:0] rd_off = log_rd_addr - LOG_BASE;
    wire logic rd_in = log_rd_addr >= LOG_BASE && rd_off < LOG_SPAN;
    wire logic [2:0] rd_ent = 3'(rd_off / 16'(LOG_WORDS));
    wire logic [2:0] rd_word = 3'(rd_off % 16'(LOG_WORDS));

    assign shut = relay_on & ~relay_nx & leader;

    always_comb begin
        pick = '0;
        pick_idx = '0;
        for (int i = NUM_RULES - 1; i >= 0; i--) begin
            if (evt_pend[i]) begin
                pick = '0;
                pick[i] = 1'b1;
                pick_idx = RI_W'(i);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            evt_pend <= '0;
            evt_strobe <= 1'b0;
            evt_rule <= '0;
            evt_dest_id <= '0;
            evt_dest_ch <= '0;
            wr_ptr <= '0;
            seq <= '0;
            for (int e = 0; e < LOG_ENTRIES; e++) begin
                for (int w = 0; w < LOG_WORDS; w++) begin
                    log_mem[e][w] <= '0;  // see [RULE_03]
                end
            end
        end else begin
            evt_pend <= (evt_pend & ~pick) | shut;
            evt_strobe <= |evt_pend;  // see [RULE_04]
            if (|evt_pend) begin
                evt_rule <= 8'(pick_idx);
                evt_dest_id <= dest_id[pick_idx];
                evt_dest_ch <= dest_ch[pick_idx];
                log_mem[wr_ptr][0] <= seq + 1'b1;  // see [RULE_02]
                log_mem[wr_ptr][1] <= LW'({dest_id[pick_idx], dest_ch[pick_idx]});
                log_mem[wr_ptr][2] <= LW'(pick_idx);
                log_mem[wr_ptr][3] <= sec_count[31:16];
                log_mem[wr_ptr][4] <= sec_count[15:0];
                seq <= seq + 1'b1;
                wr_ptr <= (wr_ptr == 3'(LOG_ENTRIES - 1)) ? '0 : wr_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            log_rd_valid <= 1'b0;
            log_rd_data <= '0;
        end else begin
            log_rd_valid <= log_rd_en;
            log_rd_data <= (log_rd_en && rd_in) ? log_mem[rd_ent][rd_word] : '0;  // see [RULE_02]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_group_off;
        @(posedge sys_clk) disable iff (!rst_b)
        !target[0] |=> !relay_on[0] ##1 (pulse_mode[0] || !dest_relay[0]);
    endproperty
    a_group_off: assert property (p_group_off) else $error("relay on while group not satisfied");  // see [RULE_01]

    property p_failsafe;
        @(posedge sys_clk) disable iff (!rst_b)
        failsafe_en && rule_en[0] && !src_valid[0] |-> !target[0];
    endproperty
    a_failsafe: assert property (p_failsafe) else $error("failsafe missed invalid data");  // see [RULE_05]

    property p_ignore;
        @(posedge sys_clk) disable iff (!rst_b)
        !failsafe_en && rule_en == NUM_RULES'(3) && !src_valid[0] && src_valid[1] && res[1]
        && dest_id[0] == dest_id[1] && dest_ch[0] == dest_ch[1] |-> target[0];
    endproperty
    a_ignore: assert property (p_ignore) else $error("missing node not ignored");  // see [RULE_06]

    property p_latch;
        @(posedge sys_clk) disable iff (!rst_b)
        hold_off_until_client_write && !relay_on[0] && !coil_hit[0] |=> !relay_on[0];
    endproperty
    a_latch: assert property (p_latch) else $error("relay re-energized without client write");  // see [RULE_07]

    property p_store;
        @(posedge sys_clk) disable iff (!rst_b)
        latch_store |=> relay_on == '0;
    endproperty
    a_store: assert property (p_store) else $error("store did not force relays off");  // see [RULE_09]

    property p_log_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        log_rd_en && !rd_in |=> log_rd_valid && log_rd_data == '0;
    endproperty
    a_log_zero: assert property (p_log_zero) else $error("unmapped log read not zero");  // see [RULE_02]

    property p_evt;
        @(posedge sys_clk) disable iff (!rst_b)
        shut[0] |=> ##[0:16] evt_strobe;
    endproperty
    a_evt: assert property (p_evt) else $error("shutdown event never reported");  // see [RULE_04]

    property p_pulse;
        @(posedge sys_clk) disable iff (!rst_b)
        |(pulse_mode & fire_go) |=> ##1 (dest_relay & $past(pulse_mode & fire_go, 2)) == $past(pulse_mode & fire_go, 2);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse not started");  // see [RULE_12]
endmodule

// [testbench/rsl_plc_model.sv]
// client side model: coil writes and event log reads
`timescale 1ns/1ps
module rsl_plc_model
    import rsl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic log_rd_valid,
    input wire logic [LW-1:0] log_rd_data,
    output logic coil_wr,
    output logic [ID_W-1:0] coil_id,
    output logic [CH_W-1:0] coil_ch,
    output logic coil_val,
    output logic log_rd_en,
    output logic [15:0] log_rd_addr
);
    initial begin
        coil_wr = 1'b0;
        coil_id = 8'h5a;
        coil_ch = 4'h5;
        coil_val = 1'b0;
        log_rd_en = 1'b0;
        log_rd_addr = 16'h5a5a;
    end
    ////////////////////////////////////////////////////////////////
    // coil write for one relay, idle lines inverted
    task automatic coil_write(input logic [ID_W-1:0] id, input logic [CH_W-1:0] ch);
        @(negedge sys_clk);
        coil_wr <= 1'b1;
        coil_id <= id;
        coil_ch <= ch;
        coil_val <= 1'b1;
        @(negedge sys_clk);
        coil_wr <= 1'b0;
        coil_id <= ~id;
        coil_ch <= ~ch;
        coil_val <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    // one holding register read, answer seen one cycle on
    task automatic log_read(input logic [15:0] a, output logic [15:0] d);
        @(negedge sys_clk);
        log_rd_en <= 1'b1;
        log_rd_addr <= a;
        @(negedge sys_clk);
        log_rd_en <= 1'b0;
        log_rd_addr <= ~a;
        d = (log_rd_valid === 1'b1) ? log_rd_data : 16'hxxxx;
    endtask
endmodule

// [testbench/rsl_remote_shutdown_logic_tb.sv]
// self-checking bench for the remote shutdown relay logic
`timescale 1ns/1ps
module rsl_remote_shutdown_logic_tb
    import rsl_pkg::*;
;
    localparam int NR = 4;
    typedef struct packed {
        logic [31:0] v;
        logic [1:0] eo;
        logic [31:0] et;
        logic [1:0] dop;
        logic [31:0] dt;
        logic x;
    } rsl_row_s;
    logic sys_clk, rst_b, failsafe_en, hold, store, log_rd_valid, evt_strobe;
    logic coil_wr, coil_val, log_rd_en;
    logic [ID_W-1:0] coil_id, evt_dest_id, f_id;
    logic [CH_W-1:0] coil_ch, evt_dest_ch, f_ch;
    logic [15:0] log_rd_addr, d;
    logic [LW-1:0] log_rd_data;
    logic [7:0] evt_rule, f_rule;
    logic [NR-1:0] rule_en, src_valid, pulse_mode, pulse_on_run, dest_relay;
    logic [1:0] local_dout;
    logic [DATA_W-1:0] src_value [NR], en_thr [NR], de_thr [NR];
    logic [1:0] en_op [NR], de_op [NR];
    logic [ID_W-1:0] dest_id [NR];
    logic [CH_W-1:0] dest_ch [NR];
    logic [PT_W-1:0] pulse_time [NR];
    rsl_row_s rows [10];
    int err_count = 0;
    int samples_checked = 0;
    int n_evt = 0;
    ////////////////////////////////////////////////////////////////
    rsl_remote_shutdown_logic #(.NUM_RULES(NR), .NUM_LOCAL(2), .TICKS_PER_SEC(10)) u_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .failsafe_en(failsafe_en), .hold_off_until_client_write(hold),
        .settings_store(store), .gateway_addr(GW_ADDR_DEF), .rule_en(rule_en), .src_valid(src_valid),
        .src_value(src_value), .en_op(en_op), .en_thr(en_thr), .de_op(de_op), .de_thr(de_thr),
        .dest_id(dest_id), .dest_ch(dest_ch), .pulse_mode(pulse_mode), .pulse_on_run(pulse_on_run),
        .pulse_time(pulse_time), .coil_wr(coil_wr), .coil_id(coil_id), .coil_ch(coil_ch),
        .coil_val(coil_val), .log_rd_en(log_rd_en), .log_rd_addr(log_rd_addr), .dest_relay(dest_relay),
        .local_dout(local_dout), .log_rd_valid(log_rd_valid), .log_rd_data(log_rd_data),
        .evt_strobe(evt_strobe), .evt_rule(evt_rule), .evt_dest_id(evt_dest_id), .evt_dest_ch(evt_dest_ch));
    rsl_plc_model u_plc (
        .sys_clk(sys_clk), .log_rd_valid(log_rd_valid), .log_rd_data(log_rd_data), .coil_wr(coil_wr),
        .coil_id(coil_id), .coil_ch(coil_ch), .coil_val(coil_val), .log_rd_en(log_rd_en),
        .log_rd_addr(log_rd_addr));
    ////////////////////////////////////////////////////////////////
    // helpers
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic rule(input int i, input logic [31:0] v, input logic [1:0] eo, input logic [31:0] et,
                        input logic [1:0] dop, input logic [31:0] dt);
        src_value[i] = v;
        en_op[i] = eo;
        en_thr[i] = et;
        de_op[i] = dop;
        de_thr[i] = dt;
    endtask
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // clock, first event capture, watchdog
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (evt_strobe === 1'b1 && n_evt == 0) begin
            f_id <= evt_dest_id;
            f_ch <= evt_dest_ch;
            f_rule <= evt_rule;
        end
        if (evt_strobe === 1'b1) n_evt <= n_evt + 1;
    end
    initial begin
        #50000;
        err_count++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        {failsafe_en, hold, store} = 3'h0;
        rule_en = 4'h1;
        src_valid = 4'hf;
        pulse_mode = 4'h8;
        pulse_on_run = 4'h8;
        for (int i = 0; i < NR; i++) begin
            rule(i, 0, OP_GT, 10, OP_LT, 5);
            dest_id[i] = 8'h05;
            dest_ch[i] = 4'h1;
            pulse_time[i] = 16'h0000;
        end
        rows = '{'{14495, OP_GT, 14000, OP_LT, 13000, 1}, '{13500, OP_GT, 14000, OP_LT, 13000, 1},
                 '{12000, OP_GT, 14000, OP_LT, 13000, 0}, '{13500, OP_GT, 14000, OP_LT, 13000, 0},
                 '{1, OP_EQ, 1, OP_EQ, 0, 1}, '{5, OP_EQ, 1, OP_EQ, 0, 1}, '{0, OP_EQ, 1, OP_EQ, 0, 0},
                 '{30, OP_GT, 10, OP_GT, 20, 0}, '{15, OP_GT, 10, OP_GT, 20, 1}, '{99, OP_OFF, 0, OP_OFF, 0, 1}};
        step(16);
        cmp("reset relays", 0, {local_dout, dest_relay});
        rst_b = 1'b1;
        step(2);
        foreach (rows[k]) begin
            rule(0, rows[k].v, rows[k].eo, rows[k].et, rows[k].dop, rows[k].dt);
            step(5);
            cmp("table relay", rows[k].x, dest_relay[0]);
        end
        cmp("event id ch", 16'h0051, {f_id, f_ch});
        cmp("event rule", 0, f_rule);
        rule(0, 99, OP_GT, 10, OP_LT, 5);
        rule(1, 10, OP_GT, 100, OP_LT, 50);
        rule_en = 4'h3;
        step(5);
        cmp("and group off", 0, dest_relay[1:0]);
        src_value[1] = 200;
        step(5);
        cmp("and group on", 2'h3, dest_relay[1:0]);
        src_valid = 4'he;
        step(5);
        cmp("missing ignored", 1, dest_relay[0]);
        failsafe_en = 1'b1;
        step(5);
        cmp("failsafe off", 0, dest_relay[0]);
        src_value[1] = 200;
        src_valid = 4'hf;
        failsafe_en = 1'b0;
        rule_en = 4'hf;
        dest_id[2] = GW_ADDR_DEF;
        rule(2, 50, OP_GT, 10, OP_LT, 5);
        dest_id[3] = 8'h09;
        dest_ch[3] = 4'h2;
        pulse_time[3] = 16'h0002;
        step(5);
        cmp("local output", 2'h2, local_dout);
        src_value[3] = 50;
        step(5);
        cmp("pulse high", 1, dest_relay[3]);
        step(40);
        cmp("pulse over", 0, dest_relay[3]);
        hold = 1'b1;
        store = 1'b1;
        step(1);
        store = 1'b0;
        step(6);
        cmp("store forces off", 0, dest_relay[0]);
        u_plc.coil_write(8'h05, 4'h1);
        step(5);
        cmp("coil re-energize", 1, dest_relay[0]);
        src_value[1] = 10;
        step(5);
        src_value[1] = 200;
        step(6);
        cmp("latched off", 0, dest_relay[0]);
        hold = 1'b0;
        // eight shutdowns so far: ring slot 0 now holds the sixth
        u_plc.log_read(LOG_BASE, d);
        cmp("log seq", 6, d);
        u_plc.log_read(LOG_BASE + 16'h0001, d);
        cmp("log dest", 16'h0f71, d);
        u_plc.log_read(LOG_BASE + 16'h0002, d);
        cmp("log rule", 2, d);
        u_plc.log_read(LOG_BASE + LOG_SPAN, d);
        cmp("log outside", 0, d);
        cmp("event count", 8, n_evt);
        rst_b = 1'b0;
        step(2);
        rst_b = 1'b1;
        rule_en = 4'h0;
        step(2);
        u_plc.log_read(LOG_BASE, d);
        cmp("log after reset", 0, d);
        wrap_up();
    end
endmodule
